// ### rtl/bbo_pkg.sv
// Package for the branch and bit-operation execution block of an 8-bit core.
// Assumes one core clock, a synchronous active-low reset and a decoder upstream
// that has already turned each instruction word into one of the operation codes below.
package bbo_pkg;

    // Status flag positions inside the status register
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;

    // Register port map and reset values
    localparam logic [3:0] OFS_STATUS = 4'h0;
    localparam logic [3:0] OFS_STATE = 4'h1;
    localparam logic [7:0] STATUS_RST = 8'h00;

    // Offset field width of a relative branch
    localparam int OFS_W = 7;

    // Operation codes handed over by the upstream decoder
    typedef enum logic [5:0] {
        OP_NONE = 6'h00,
        OP_BRANCH_ON_FLAG_SET = 6'h01, OP_BRANCH_ON_FLAG_CLEAR = 6'h02,
        OP_BRANCH_IF_EQUAL = 6'h03, OP_BRANCH_IF_NOT_EQUAL = 6'h04,
        OP_BRANCH_IF_CARRY_SET = 6'h05, OP_BRANCH_IF_CARRY_CLEAR = 6'h06,
        OP_BRANCH_IF_SAME_OR_HIGHER = 6'h07, OP_BRANCH_IF_LOWER = 6'h08,
        OP_BRANCH_IF_MINUS = 6'h09, OP_BRANCH_IF_PLUS = 6'h0A,
        OP_BRANCH_SIGNED_GE = 6'h0B, OP_BRANCH_SIGNED_LT = 6'h0C,
        OP_BRANCH_HALF_CARRY_SET = 6'h0D, OP_BRANCH_HALF_CARRY_CLEAR = 6'h0E,
        OP_BRANCH_TRANSFER_SET = 6'h0F, OP_BRANCH_TRANSFER_CLEAR = 6'h10,
        OP_BRANCH_OVERFLOW_SET = 6'h11, OP_BRANCH_OVERFLOW_CLEAR = 6'h12,
        OP_BRANCH_IRQ_ENABLED = 6'h13, OP_BRANCH_IRQ_DISABLED = 6'h14,
        OP_SET_IO_BIT = 6'h15, OP_CLEAR_IO_BIT = 6'h16,
        OP_ROTATE_RIGHT_CARRY = 6'h17, OP_ARITH_SHIFT_RIGHT = 6'h18,
        OP_BIT_TO_TRANSFER_FLAG = 6'h19, OP_TRANSFER_FLAG_TO_BIT = 6'h1A,
        OP_GENERIC_FLAG_SET = 6'h1B, OP_GENERIC_FLAG_CLEAR = 6'h1C,
        OP_GLOBAL_IRQ_ON = 6'h1D, OP_GLOBAL_IRQ_OFF = 6'h1E,
        OP_SET_CARRY = 6'h1F, OP_CLEAR_CARRY = 6'h20,
        OP_SET_ZERO = 6'h21, OP_CLEAR_ZERO = 6'h22,
        OP_SET_NEGATIVE = 6'h23, OP_CLEAR_NEGATIVE = 6'h24,
        OP_SIGN_FLAG_SET_OP = 6'h25, OP_CLEAR_SIGN = 6'h26,
        OP_SET_OVERFLOW = 6'h27, OP_CLEAR_OVERFLOW = 6'h28,
        OP_SET_TRANSFER = 6'h29, OP_CLEAR_TRANSFER = 6'h2A,
        OP_SET_HALF_CARRY = 6'h2B, OP_CLEAR_HALF_CARRY = 6'h2C
    } bbo_op_t;

    // Sequencer states, Gray coded along idle -> hold -> idle
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HOLD = 2'b01
    } bbo_state_t;

endpackage : bbo_pkg

// ### rtl/bbo_core.sv
// Execution block for flag branches and bit operations of an 8-bit core.
// Holds the status register itself. Assumes all instruction inputs come from
// logic on the same clock and that the io space applies a single-bit write.
`timescale 1ns/1ps
module bbo_core
    import bbo_pkg::*;
#(
    parameter int PC_W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    // Instruction issue
    input wire logic instr_valid,
    input wire bbo_op_t instr_op,
    input wire logic [2:0] instr_flag_sel,
    input wire logic [2:0] instr_bit_sel,
    input wire logic [OFS_W-1:0] instr_offset,
    input wire logic [PC_W-1:0] instr_pc,
    input wire logic [7:0] instr_rd_val,
    input wire logic [5:0] instr_io_addr,
    output logic instr_ready,
    output logic instr_done,
    // Program counter redirect
    output logic pc_load,
    output logic [PC_W-1:0] pc_target,
    // Register file write back
    output logic rd_we,
    output logic [7:0] rd_wdata,
    // Io single-bit write
    output logic io_we,
    output logic [5:0] io_addr,
    output logic [2:0] io_bit,
    output logic io_bit_val,
    // Status register view for the rest of the core
    output logic [7:0] status_out,
    // Software register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);

    bbo_state_t state_q, state_d;
    logic [7:0] status_q, status_d;
    logic ready_q, done_q, pc_load_q, rd_we_q, io_we_q, io_bit_val_q, last_taken_q;
    logic [PC_W-1:0] pc_target_q;
    logic [7:0] rd_wdata_q, reg_rdata_q;
    logic [5:0] io_addr_q;
    logic [2:0] io_bit_q;

    // Condition selection for each branch code
    function automatic logic [1:0] br_select(input bbo_op_t op, input logic [7:0] st, input logic [2:0] sel);
        logic is_br;
        logic cond;
        is_br = 1'b1;
        cond = 1'b0;
        unique case (op)
            OP_BRANCH_ON_FLAG_SET: cond = st[sel];
            OP_BRANCH_ON_FLAG_CLEAR: cond = ~st[sel];
            OP_BRANCH_IF_EQUAL: cond = st[FLAG_Z];
            OP_BRANCH_IF_NOT_EQUAL: cond = ~st[FLAG_Z];
            OP_BRANCH_IF_CARRY_SET, OP_BRANCH_IF_LOWER: cond = st[FLAG_C];
            OP_BRANCH_IF_CARRY_CLEAR, OP_BRANCH_IF_SAME_OR_HIGHER: cond = ~st[FLAG_C];
            OP_BRANCH_IF_MINUS: cond = st[FLAG_N];
            OP_BRANCH_IF_PLUS: cond = ~st[FLAG_N];
            OP_BRANCH_SIGNED_GE: cond = ~(st[FLAG_N] ^ st[FLAG_V]);
            OP_BRANCH_SIGNED_LT: cond = st[FLAG_N] ^ st[FLAG_V];
            OP_BRANCH_HALF_CARRY_SET: cond = st[FLAG_H];
            OP_BRANCH_HALF_CARRY_CLEAR: cond = ~st[FLAG_H];
            OP_BRANCH_TRANSFER_SET: cond = st[FLAG_T];
            OP_BRANCH_TRANSFER_CLEAR: cond = ~st[FLAG_T];
            OP_BRANCH_OVERFLOW_SET: cond = st[FLAG_V];
            OP_BRANCH_OVERFLOW_CLEAR: cond = ~st[FLAG_V];
            OP_BRANCH_IRQ_ENABLED: cond = st[FLAG_I];
            OP_BRANCH_IRQ_DISABLED: cond = ~st[FLAG_I];
            default: is_br = 1'b0;
        endcase
        return {is_br, cond};
    endfunction : br_select

    // Flag touched by a flag set or clear code: {hit, value, index}
    function automatic logic [4:0] flag_select(input bbo_op_t op, input logic [2:0] sel);
        logic hit;
        logic val;
        logic [2:0] idx;
        hit = 1'b1;
        val = 1'b0;
        idx = sel;
        unique case (op)
            OP_GENERIC_FLAG_SET: val = 1'b1;
            OP_GENERIC_FLAG_CLEAR: val = 1'b0;
            OP_GLOBAL_IRQ_ON: begin
                val = 1'b1;
                idx = FLAG_I;
            end
            OP_GLOBAL_IRQ_OFF: idx = FLAG_I;
            OP_SET_CARRY: begin
                val = 1'b1;
                idx = FLAG_C;
            end
            OP_CLEAR_CARRY: idx = FLAG_C;
            OP_SET_ZERO: begin
                val = 1'b1;
                idx = FLAG_Z;
            end
            OP_CLEAR_ZERO: idx = FLAG_Z;
            OP_SET_NEGATIVE: begin
                val = 1'b1;
                idx = FLAG_N;
            end
            OP_CLEAR_NEGATIVE: idx = FLAG_N;
            OP_SIGN_FLAG_SET_OP: begin
                val = 1'b1;
                idx = FLAG_S;
            end
            OP_CLEAR_SIGN: idx = FLAG_S;
            OP_SET_OVERFLOW: begin
                val = 1'b1;
                idx = FLAG_V;
            end
            OP_CLEAR_OVERFLOW: idx = FLAG_V;
            OP_SET_TRANSFER: begin
                val = 1'b1;
                idx = FLAG_T;
            end
            OP_CLEAR_TRANSFER: idx = FLAG_T;
            OP_SET_HALF_CARRY: begin
                val = 1'b1;
                idx = FLAG_H;
            end
            OP_CLEAR_HALF_CARRY: idx = FLAG_H;
            default: hit = 1'b0;
        endcase
        return {hit, val, idx};
    endfunction : flag_select

    // Decode of the offered instruction
    wire logic accept_w = instr_valid & ready_q;
    wire logic [1:0] br_w = br_select(instr_op, status_q, instr_flag_sel);
    wire logic is_branch_w = br_w[1];
    wire logic taken_w = br_w[1] & br_w[0];
    wire logic [4:0] fl_w = flag_select(instr_op, instr_flag_sel);
    wire logic is_io_w = (instr_op == OP_SET_IO_BIT) || (instr_op == OP_CLEAR_IO_BIT);
    wire logic is_rot_w = (instr_op == OP_ROTATE_RIGHT_CARRY);
    wire logic is_sra_w = (instr_op == OP_ARITH_SHIFT_RIGHT);
    wire logic is_shift_w = is_rot_w | is_sra_w;
    wire logic is_tstore_w = (instr_op == OP_BIT_TO_TRANSFER_FLAG);
    wire logic is_tload_w = (instr_op == OP_TRANSFER_FLAG_TO_BIT);

    // Relative target: counter plus sign-extended offset plus one
    wire logic [PC_W-1:0] offset_ext_w = {{(PC_W-OFS_W){instr_offset[OFS_W-1]}}, instr_offset};
    wire logic [PC_W-1:0] target_w = instr_pc + offset_ext_w + PC_W'(1);

    // Shift results; rotate feeds old carry in, the arithmetic form keeps the sign
    wire logic [7:0] rot_res_w = {status_q[FLAG_C], instr_rd_val[7:1]};
    wire logic [7:0] sra_res_w = {instr_rd_val[7], instr_rd_val[7:1]};
    wire logic [7:0] shift_res_w = is_rot_w ? rot_res_w : sra_res_w;
    wire logic shift_c_w = instr_rd_val[0];
    wire logic shift_n_w = shift_res_w[7];
    wire logic shift_z_w = (shift_res_w == 8'h00);

    // Bit load result: one bit replaced by the transfer flag
    wire logic [7:0] bit_mask_w = 8'h01 << instr_bit_sel;
    wire logic [7:0] tload_res_w = status_q[FLAG_T] ? (instr_rd_val | bit_mask_w)
                                                  : (instr_rd_val & ~bit_mask_w);

    // Software port decode
    wire logic sw_status_wr_w = reg_wr && (reg_addr == OFS_STATUS);
    wire logic [7:0] state_view_w = {6'h00, last_taken_q, (state_q != ST_IDLE)};
    wire logic [7:0] rdata_w = (reg_addr == OFS_STATUS) ? status_q :
                               (reg_addr == OFS_STATE) ? state_view_w : 8'h00;

    // Next status value; the flags an executing instruction updates win over a software write
    // in the same cycle, since the core's own result must never be lost
    always_comb begin
        status_d = sw_status_wr_w ? reg_wdata : status_q;
        if (accept_w && is_shift_w) begin
            status_d[FLAG_C] = shift_c_w;
            status_d[FLAG_Z] = shift_z_w;
            status_d[FLAG_N] = shift_n_w;
            status_d[FLAG_V] = shift_n_w ^ shift_c_w;
        end
        if (accept_w && is_tstore_w) begin
            status_d[FLAG_T] = instr_rd_val[instr_bit_sel];
        end
        if (accept_w && fl_w[4]) begin
            status_d[fl_w[2:0]] = fl_w[3];
        end
    end

    // Sequencer: taken branches and io bit writes hold one extra cycle
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (accept_w && (taken_w || is_io_w)) begin
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD: state_d = ST_IDLE;
            // Two spare codes of the state word fall back to idle
            default: state_d = ST_IDLE;
        endcase
    end

    // State, status and handshake flops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            status_q <= STATUS_RST;
            ready_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            status_q <= status_d;
            ready_q <= (state_d == ST_IDLE);
            // Done marks the last cycle of every instruction
            done_q <= (accept_w && !(taken_w || is_io_w)) || (state_q == ST_HOLD);
        end
    end

    // Program counter redirect, a one-cycle pulse in the second branch cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pc_load_q <= 1'b0;
            pc_target_q <= '0;
            last_taken_q <= 1'b0;
        end else begin
            pc_load_q <= accept_w && taken_w;
            if (accept_w && taken_w) begin
                pc_target_q <= target_w;
            end
            if (accept_w && is_branch_w) begin
                last_taken_q <= taken_w;
            end
        end
    end

    // Register file write back for shifts and bit load
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_we_q <= 1'b0;
            rd_wdata_q <= 8'h00;
        end else begin
            rd_we_q <= accept_w && (is_shift_w || is_tload_w);
            if (accept_w && is_shift_w) begin
                rd_wdata_q <= shift_res_w;
            end else if (accept_w && is_tload_w) begin
                rd_wdata_q <= tload_res_w;
            end
        end
    end

    // Io bit write; the io space alters only the named bit, so no read is needed
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            io_we_q <= 1'b0;
            io_addr_q <= 6'h00;
            io_bit_q <= 3'h0;
            io_bit_val_q <= 1'b0;
        end else begin
            io_we_q <= accept_w && is_io_w;
            if (accept_w && is_io_w) begin
                io_addr_q <= instr_io_addr;
                io_bit_q <= instr_bit_sel;
                io_bit_val_q <= (instr_op == OP_SET_IO_BIT);
            end
        end
    end

    // Read data, valid the cycle after the strobe only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata_q <= 8'h00;
        end else begin
            reg_rdata_q <= reg_rd ? rdata_w : 8'h00;
        end
    end

    assign instr_ready = ready_q;
    assign instr_done = done_q;
    assign pc_load = pc_load_q;
    assign pc_target = pc_target_q;
    assign rd_we = rd_we_q;
    assign rd_wdata = rd_wdata_q;
    assign io_we = io_we_q;
    assign io_addr = io_addr_q;
    assign io_bit = io_bit_q;
    assign io_bit_val = io_bit_val_q;
    assign status_out = status_q;
    assign reg_rdata = reg_rdata_q;

endmodule : bbo_core

// ### verification/bbo_core_assertions.sv
// Concurrent checks on the ports of the branch and bit-operation block.
// Assumes the hand-over timing: results land at the accepting edge, pulses last one cycle.
`timescale 1ns/1ps
module bbo_core_assertions
    import bbo_pkg::*;
#(
    parameter int PC_W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire bbo_op_t instr_op,
    input wire logic [2:0] instr_flag_sel,
    input wire logic [2:0] instr_bit_sel,
    input wire logic [OFS_W-1:0] instr_offset,
    input wire logic [PC_W-1:0] instr_pc,
    input wire logic [7:0] instr_rd_val,
    input wire logic [5:0] instr_io_addr,
    input wire logic instr_ready,
    input wire logic instr_done,
    input wire logic pc_load,
    input wire logic [PC_W-1:0] pc_target,
    input wire logic rd_we,
    input wire logic [7:0] rd_wdata,
    input wire logic io_we,
    input wire logic [5:0] io_addr,
    input wire logic [2:0] io_bit,
    input wire logic io_bit_val,
    input wire logic [7:0] status_out,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Accept strobe and the relative target of the offered branch
    wire logic acc = instr_valid && instr_ready;
    wire logic [PC_W-1:0] tgt_w = instr_pc + {{(PC_W-OFS_W){instr_offset[OFS_W-1]}}, instr_offset} + PC_W'(1);

    flag_set_tgt_a: assert property (acc && instr_op == OP_BRANCH_ON_FLAG_SET && status_out[instr_flag_sel]
        |=> pc_load && pc_target == $past(tgt_w)) else $error("flag set branch target wrong");
    flag_clr_skip_a: assert property (acc && instr_op == OP_BRANCH_ON_FLAG_CLEAR && status_out[instr_flag_sel]
        |=> !pc_load && instr_done && instr_ready) else $error("flag clear branch taken on set flag");
    branch_flags_a: assert property (acc && !reg_wr
        && instr_op inside {[OP_BRANCH_ON_FLAG_SET:OP_BRANCH_IRQ_DISABLED]} |=> $stable(status_out))
        else $error("branch changed status");
    lower_carry_a: assert property (acc && instr_op == OP_BRANCH_IF_LOWER
        |=> pc_load == $past(status_out[FLAG_C])) else $error("lower branch not tied to carry");
    signed_lt_a: assert property (acc && instr_op == OP_BRANCH_SIGNED_LT
        |=> pc_load == $past(status_out[FLAG_N] ^ status_out[FLAG_V])) else $error("signed lt decision wrong");
    io_pulse_a: assert property (io_we |-> !instr_ready ##1 (!io_we && instr_ready && instr_done))
        else $error("io write not two cycles");
    io_value_a: assert property (acc && instr_op == OP_CLEAR_IO_BIT |=> io_we && !io_bit_val
        && io_bit == $past(instr_bit_sel) && io_addr == $past(instr_io_addr)) else $error("io clear wrong");
    sra_keep_a: assert property (acc && instr_op == OP_ARITH_SHIFT_RIGHT |=> rd_we
        && rd_wdata == {$past(instr_rd_val[7]), $past(instr_rd_val[7:1])} && status_out[FLAG_C] == $past(instr_rd_val[0]))
        else $error("shift result wrong");
    flag_clear_one_a: assert property (acc && !reg_wr && instr_op == OP_GENERIC_FLAG_CLEAR
        |=> status_out == ($past(status_out) & ~(8'h01 << $past(instr_flag_sel)))) else $error("flag clear wrong");
    irq_on_a: assert property (acc && !reg_wr && instr_op == OP_GLOBAL_IRQ_ON
        |=> status_out == ($past(status_out) | 8'h80)) else $error("irq on wrong");
    taken_two_a: assert property (pc_load |-> !instr_ready ##1 (instr_done && !pc_load))
        else $error("taken branch not two cycles");

    // Main scenarios reached
    taken_c: cover property (pc_load);
    io_c: cover property (io_we);
    rd_c: cover property (rd_we);
endmodule : bbo_core_assertions

// ### verification/tb_branch_and_bit_ops.sv
// Self-checking bench for the branch and bit-operation block: an opcode sweep, then a
// random instruction stream with software status writes. Assumes the hand-over timing.
`timescale 1ns/1ps
module tb_branch_and_bit_ops;
    import bbo_pkg::*;
    logic clk, rst_n, instr_valid, instr_ready, instr_done, pc_load, rd_we, io_we, io_bit_val, reg_wr, reg_rd;
    bbo_op_t instr_op;
    logic [2:0] instr_flag_sel, instr_bit_sel, io_bit;
    logic [OFS_W-1:0] instr_offset;
    logic [15:0] instr_pc, pc_target;
    logic [7:0] instr_rd_val, rd_wdata, status_out, reg_wdata, reg_rdata, st;
    logic [5:0] instr_io_addr, io_addr;
    logic [3:0] reg_addr;
    logic [15:0] q_pc[$], q_rd[$], q_io[$], q_st[$], q_rr[$];
    logic rr_due, last_tk;
    logic [31:0] seed = 32'h0000EE9F;
    int fail_count, checks;
    localparam logic [2:0] FPOS [7] = '{FLAG_C, FLAG_Z, FLAG_N, FLAG_S, FLAG_V, FLAG_T, FLAG_H};

    bbo_core #(.PC_W(16)) DUT (.*);

    // Free-running core clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Branch decision from the bench's own status copy
    function automatic logic cond(bbo_op_t op, logic [2:0] f, logic [7:0] s);
        case (op)
            OP_BRANCH_ON_FLAG_SET: return s[f];
            OP_BRANCH_ON_FLAG_CLEAR: return !s[f];
            OP_BRANCH_IF_EQUAL: return s[FLAG_Z];
            OP_BRANCH_IF_NOT_EQUAL: return !s[FLAG_Z];
            OP_BRANCH_IF_CARRY_SET, OP_BRANCH_IF_LOWER: return s[FLAG_C];
            OP_BRANCH_IF_CARRY_CLEAR, OP_BRANCH_IF_SAME_OR_HIGHER: return !s[FLAG_C];
            OP_BRANCH_IF_MINUS: return s[FLAG_N];
            OP_BRANCH_IF_PLUS: return !s[FLAG_N];
            OP_BRANCH_SIGNED_GE: return !(s[FLAG_N] ^ s[FLAG_V]);
            OP_BRANCH_SIGNED_LT: return s[FLAG_N] ^ s[FLAG_V];
            OP_BRANCH_HALF_CARRY_SET: return s[FLAG_H];
            OP_BRANCH_HALF_CARRY_CLEAR: return !s[FLAG_H];
            OP_BRANCH_TRANSFER_SET: return s[FLAG_T];
            OP_BRANCH_TRANSFER_CLEAR: return !s[FLAG_T];
            OP_BRANCH_OVERFLOW_SET: return s[FLAG_V];
            OP_BRANCH_OVERFLOW_CLEAR: return !s[FLAG_V];
            OP_BRANCH_IRQ_ENABLED: return s[FLAG_I];
            default: return !s[FLAG_I];
        endcase
    endfunction : cond

    task automatic cmp(string n, logic [15:0] e, logic [15:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : cmp

    // Oldest note of a queue against a seen result; a result with no note is a mismatch
    task automatic chk(ref logic [15:0] q[$], input logic [15:0] g, input string n);
        if (q.size() == 0) begin
            checks++;
            fail_count++;
            $display("BAD %s exp none got %h", n, g);
        end else cmp(n, q.pop_front(), g);
    endtask : chk

    // Offers one instruction with random fields, notes its results, returns at the accepting edge
    task automatic issue(bbo_op_t op);
        logic [31:0] x, y;
        logic [15:0] tgt;
        logic [7:0] r;
        int d;
        x = rnd();
        y = rnd();
        instr_valid <= 1'b1;
        instr_op <= op;
        instr_flag_sel <= x[2:0];
        instr_bit_sel <= x[5:3];
        instr_offset <= x[12:6];
        instr_io_addr <= x[18:13];
        instr_rd_val <= x[26:19];
        instr_pc <= y[15:0];
        tgt = y[15:0] + {{9{x[12]}}, x[12:6]} + 16'h0001;
        if (op <= OP_BRANCH_IRQ_DISABLED) begin
            last_tk = cond(op, x[2:0], st);
            if (last_tk) q_pc.push_back(tgt);
        end else if (op <= OP_CLEAR_IO_BIT) q_io.push_back({6'h00, x[18:13], x[5:3], op == OP_SET_IO_BIT});
        else if (op <= OP_ARITH_SHIFT_RIGHT) begin
            r = {(op == OP_ROTATE_RIGHT_CARRY) ? st[FLAG_C] : x[26], x[26:20]};
            st[FLAG_C] = x[19];
            st[FLAG_N] = r[7];
            st[FLAG_Z] = (r == 8'h00);
            st[FLAG_V] = r[7] ^ x[19];
            q_rd.push_back({8'h00, r});
        end else if (op == OP_BIT_TO_TRANSFER_FLAG) st[FLAG_T] = x[19 + x[5:3]];
        else if (op == OP_TRANSFER_FLAG_TO_BIT) begin
            r = x[26:19];
            r[x[5:3]] = st[FLAG_T];
            q_rd.push_back({8'h00, r});
        end else if (op <= OP_GENERIC_FLAG_CLEAR) st[x[2:0]] = (op == OP_GENERIC_FLAG_SET);
        else if (op <= OP_GLOBAL_IRQ_OFF) st[FLAG_I] = (op == OP_GLOBAL_IRQ_ON);
        else begin
            d = op - OP_SET_CARRY;
            st[FPOS[d / 2]] = (d % 2 == 0);
        end
        q_st.push_back({8'h00, st});
        @(negedge clk);
        while (instr_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
    endtask : issue

    // One register port cycle; the caller drops the strobes after the last one
    task automatic reg_op(logic wr, logic [3:0] a, logic [7:0] d, logic [7:0] e);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= a;
        reg_wdata <= d;
        if (!wr) q_rr.push_back({8'h00, e});
        else if (a == OFS_STATUS) st = d;
        @(posedge clk);
    endtask : reg_op

    // Results are sampled mid-cycle, where every pulse is settled and seen once
    always @(negedge clk) begin
        if (pc_load === 1'b1) chk(q_pc, pc_target, "pc_target");
        if (rd_we === 1'b1) chk(q_rd, {8'h00, rd_wdata}, "rd_wdata");
        if (io_we === 1'b1) chk(q_io, {6'h00, io_addr, io_bit, io_bit_val}, "io_write");
        if (instr_done === 1'b1) chk(q_st, {8'h00, status_out}, "status_out");
        if (rr_due) chk(q_rr, {8'h00, reg_rdata}, "reg_rdata");
        rr_due = (reg_rd === 1'b1);
    end

    task automatic summarize();
        if (fail_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize

    // Hang guard at 20000 cycles, well beyond the under two thousand cycles the stream needs
    initial begin
        #(20 * 20000);
        fail_count++;
        summarize();
    end

    // Main sequence: reset, every opcode but OP_NONE once, then random bursts with software accesses
    initial begin
        logic [31:0] w;
        rst_n = 1'b0;
        instr_op = OP_NONE;
        {instr_valid, reg_wr, reg_rd, rr_due, last_tk} = 5'h00;
        {instr_flag_sel, instr_bit_sel, instr_offset, instr_pc, instr_rd_val, instr_io_addr} = '0;
        {reg_addr, reg_wdata} = 12'h000;
        st = STATUS_RST;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        reg_op(1'b0, OFS_STATUS, 8'h00, STATUS_RST);
        reg_rd <= 1'b0;
        for (int c = 1; c <= 44; c++) issue(bbo_op_t'(6'(c)));
        for (int i = 0; i < 60; i++) begin
            for (int j = 0; j < 12; j++) begin
                w = rnd();
                issue(bbo_op_t'(6'(w % 44 + 1)));
            end
            instr_valid <= 1'b0;
            repeat (2) @(posedge clk);
            w = rnd();
            reg_op(1'b0, OFS_STATE, 8'h00, {6'h00, last_tk, 1'b0});
            reg_op(1'b1, OFS_STATUS, w[7:0], 8'h00);
            reg_op(1'b1, 4'hF, ~w[7:0], 8'h00);
            reg_op(1'b0, OFS_STATUS, 8'h00, st);
            reg_op(1'b0, 4'hF, 8'h00, 8'h00);
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
        end
        instr_valid <= 1'b0;
        repeat (4) @(posedge clk);
        cmp("notes_left", 16'h0000, 16'(q_pc.size() + q_rd.size() + q_io.size() + q_st.size() + q_rr.size()));
        summarize();
    end
endmodule : tb_branch_and_bit_ops

bind bbo_core bbo_core_assertions #(.PC_W(PC_W)) u_chk (.*);
